// *** rtl/autobaud_wake.sv ***
`default_nettype none
module autobaud_wake
   import uart_abd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   serial_link_if.device link,
   input wire logic sync_mode_i,
   input wire logic wide_divisor_mode_i,
   input wire logic high_speed_select_i,
   input wire logic sleep_i,
   input wire logic autobaud_enable_set_i,
   input wire logic autobaud_enable_clr_i,
   input wire logic overflow_clr_i,
   input wire logic wake_enable_set_i,
   input wire logic wake_enable_clr_i,
   input wire logic divisor_wr_i,
   input wire logic [15:0] divisor_wdata_i,
   input wire logic rcv_data_read_i,
   output logic autobaud_enable_o,
   output logic wake_on_break_enable_o,
   output logic autobaud_overflow_flag_o,
   output logic receive_int_flag_o,
   output logic [15:0] divisor_pair_o,
   output logic receiver_idle_flag_o,
   output logic receive_hold_o,
   output logic [7:0] receive_data_o
);
   abd_state_e state_q, state_d;
   logic rx_meta_q, rx_sync_q, rx_prev_q;
   logic autobaud_enable_q, autobaud_enable_d;
   logic wue_q, wue_d;
   logic ovf_q, ovf_d;
   logic receive_int_flag_q, receive_int_flag_d;
   logic pend_q, pend_d;
   logic hold_q, idle_q;
   logic [1:0] qphase_q;
   logic [2:0] rises_q, rises_d;
   logic [15:0] div_q, div_d;
   logic [15:0] base_div;
   logic abd_tick;

   wire logic fall = rx_prev_q && !rx_sync_q;
   wire logic rise = !rx_prev_q && rx_sync_q;
   wire logic in_abd = (state_q == ST_ABD_FIRST) || (state_q == ST_ABD_COUNT);
   wire logic first_rise = (state_q == ST_ABD_FIRST) && rise;
   wire logic abd_done = (state_q == ST_ABD_COUNT) && rise &&
                         (rises_q == SYNC_RISES - 3'h1);
   wire logic counting = (state_q == ST_ABD_COUNT) && !abd_done;
   wire logic wrap = counting && abd_tick && (div_q == DIVISOR_MAX);
   wire logic wake_fall = (state_q == ST_WAKE_WATCH) && fall;
   wire logic wake_end = (state_q == ST_WAKE_LOW) && rise;
   wire logic q_edge = (qphase_q == Q_LAST);
   wire logic wake_fire = (wake_fall && sleep_i) || (pend_q && q_edge);
   wire logic [1:0] mode_sum = {1'b0, wide_divisor_mode_i} +
                               {1'b0, high_speed_select_i};

   // one of three base rates, one set bit counts as the middle rate
   assign base_div = (mode_sum == 2'h0) ? BASE_DIV_SLOW :
                     (mode_sum == 2'h1) ? BASE_DIV_MID :
                     BASE_DIV_FAST;

   tick_gen #(.W(16)) abd_clk (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .restart_i(first_rise),
      .period_i(base_div << ABD_SHIFT),
      .tick_o(abd_tick)
   );

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (wue_q)
               state_d = ST_WAKE_WATCH;
            else if (autobaud_enable_q)
               state_d = ST_ABD_START;
         ST_WAKE_WATCH:
            if (!wue_q)
               state_d = ST_IDLE;
            else if (fall)
               state_d = ST_WAKE_LOW;
         ST_WAKE_LOW:
            if (!wue_q && !wake_end)
               state_d = ST_IDLE;
            else if (rise)
               // first rise ends the wake low time, rest is a fragment unless autobaud is enabled
               state_d = autobaud_enable_q ? ST_ABD_START : ST_IDLE;
         ST_ABD_START:
            if (!autobaud_enable_q)
               state_d = ST_IDLE;
            else if (fall)
               state_d = ST_ABD_FIRST;
         ST_ABD_FIRST:
            if (!autobaud_enable_q)
               state_d = ST_IDLE;
            else if (rise)
               state_d = ST_ABD_COUNT;
         ST_ABD_COUNT:
            if (!autobaud_enable_q || abd_done)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_comb
   begin
      rises_d = rises_q;
      if (first_rise)
         rises_d = 3'h1;
      else if ((state_q == ST_ABD_COUNT) && rise)
         rises_d = rises_q + 3'h1;
   end

   always_comb
   begin
      div_d = div_q;
      if (first_rise)
         div_d = DIVISOR_START;
      else if (counting && abd_tick)
         div_d = div_q + 16'h0001;
      else if (divisor_wr_i && !in_abd)
         div_d = divisor_wdata_i;
   end

   always_comb
   begin
      autobaud_enable_d = autobaud_enable_q;
      if (abd_done || autobaud_enable_clr_i)
         autobaud_enable_d = 1'b0;
      if (autobaud_enable_set_i)
         autobaud_enable_d = 1'b1;
   end

   always_comb
   begin
      wue_d = wue_q;
      if (wake_end || wake_enable_clr_i)
         wue_d = 1'b0;
      if (wake_enable_set_i)
         wue_d = 1'b1;
      if (sync_mode_i)
         wue_d = 1'b0;
   end

   always_comb
   begin
      ovf_d = ovf_q;
      if (overflow_clr_i && !autobaud_enable_q)
         ovf_d = 1'b0;
      if (wrap)
         ovf_d = 1'b1;
   end

   always_comb
   begin
      receive_int_flag_d = receive_int_flag_q;
      if (rcv_data_read_i)
         receive_int_flag_d = 1'b0;
      if (abd_done || wake_fire)
         receive_int_flag_d = 1'b1;
   end

   // awake the flag waits for the last phase, asleep it is raised at once
   assign pend_d = (wake_fall && !sleep_i) || (pend_q && !q_edge);

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end
      else
      begin
         rx_meta_q <= link.receive_line;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= ST_IDLE;
         autobaud_enable_q <= 1'b0;
         wue_q <= 1'b0;
         ovf_q <= 1'b0;
         receive_int_flag_q <= 1'b0;
         pend_q <= 1'b0;
         qphase_q <= 2'h0;
         rises_q <= 3'h0;
         div_q <= DIVISOR_RESET;
      end
      else
      begin
         state_q <= state_d;
         autobaud_enable_q <= autobaud_enable_d;
         wue_q <= wue_d;
         ovf_q <= ovf_d;
         receive_int_flag_q <= receive_int_flag_d;
         pend_q <= pend_d;
         qphase_q <= qphase_q + 2'h1;
         rises_q <= rises_d;
         div_q <= div_d;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         hold_q <= 1'b0;
         idle_q <= 1'b1;
      end
      else
      begin
         hold_q <= (state_d != ST_IDLE) || wue_d || autobaud_enable_d;
         idle_q <= (state_d == ST_IDLE) || (state_d == ST_WAKE_WATCH) ||
                   (state_d == ST_ABD_START);
      end
   end

   assign autobaud_enable_o = autobaud_enable_q;
   assign wake_on_break_enable_o = wue_q;
   assign autobaud_overflow_flag_o = ovf_q;
   assign receive_int_flag_o = receive_int_flag_q;
   assign divisor_pair_o = div_q;
   assign receiver_idle_flag_o = idle_q;
   assign receive_hold_o = hold_q;
   assign receive_data_o = RX_DATA_RESET;
endmodule
`default_nettype wire

// *** rtl/lin_break_node.sv ***
`default_nettype none
module lin_break_node
   import uart_abd_pkg::*;
#(
   parameter logic [15:0] BIT_CYCLES = NODE_BIT_CYCLES,
   parameter logic [4:0] BREAK_BITS = NODE_BREAK_BITS
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   serial_link_if.node link,
   input wire logic send_i,
   input wire logic with_break_i,
   output logic busy_o
);
   node_state_e state_q;
   logic line_q;
   logic busy_q;
   logic [4:0] bits_q;
   logic [9:0] shift_q;
   logic bit_tick;

   wire logic start = (state_q == NODE_IDLE) && send_i;

   tick_gen #(.W(16)) bit_clk (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .restart_i(start),
      .period_i(BIT_CYCLES),
      .tick_o(bit_tick)
   );

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= NODE_IDLE;
         line_q <= 1'b1;
         busy_q <= 1'b0;
         bits_q <= 5'h00;
         shift_q <= 10'h3ff;
      end
      else
      begin
         case (state_q)
            NODE_IDLE:
               if (send_i)
               begin
                  busy_q <= 1'b1;
                  bits_q <= 5'h00;
                  shift_q <= {1'b1, SYNC_CHAR, 1'b0};
                  state_q <= with_break_i ? NODE_BREAK : NODE_FRAME;
                  line_q <= 1'b0;
               end
            NODE_BREAK:
               if (bit_tick)
               begin
                  bits_q <= bits_q + 5'h01;
                  if (bits_q == BREAK_BITS - 5'h01)
                  begin
                     line_q <= 1'b1;
                     state_q <= NODE_DELIM;
                  end
               end
            NODE_DELIM:
               if (bit_tick)
               begin
                  bits_q <= 5'h00;
                  line_q <= 1'b0;
                  state_q <= NODE_FRAME;
               end
            NODE_FRAME:
               if (bit_tick)
               begin
                  bits_q <= bits_q + 5'h01;
                  shift_q <= {1'b1, shift_q[9:1]};
                  line_q <= shift_q[1];
                  if (bits_q == {1'b0, FRAME_BITS} - 5'h01)
                  begin
                     line_q <= 1'b1;
                     busy_q <= 1'b0;
                     state_q <= NODE_IDLE;
                  end
               end
            default:
               state_q <= NODE_IDLE;
         endcase
      end
   end

   assign link.receive_line = line_q;
   assign busy_o = busy_q;
endmodule
`default_nettype wire

// *** rtl/serial_link_if.sv ***
`default_nettype none
interface serial_link_if;
   logic receive_line;
   modport device (input receive_line);
   modport node (output receive_line);
endinterface
`default_nettype wire

// *** rtl/tick_gen.sv ***
`default_nettype none
module tick_gen #(
   parameter int unsigned W = 16
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic restart_i,
   input wire logic [W-1:0] period_i,
   output logic tick_o
);
   logic [W-1:0] cnt_q;
   wire logic at_end;

   assign at_end = (cnt_q == period_i - W'(1));
   assign tick_o = !restart_i && at_end;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         cnt_q <= '0;
      else if (restart_i || at_end)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + W'(1);
   end
endmodule
`default_nettype wire

// *** rtl/uart_abd_pkg.sv ***
`default_nettype none
package uart_abd_pkg;
   localparam logic [15:0] BASE_DIV_SLOW = 16'h0040;
   localparam logic [15:0] BASE_DIV_MID = 16'h0010;
   localparam logic [15:0] BASE_DIV_FAST = 16'h0004;
   localparam int unsigned ABD_SHIFT = 3;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;
   localparam logic [15:0] DIVISOR_START = 16'h0001;
   localparam logic [15:0] DIVISOR_MAX = 16'hffff;
   localparam logic [2:0] SYNC_RISES = 3'h5;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [7:0] SYNC_CHAR = 8'h55;
   localparam logic [7:0] RX_DATA_RESET = 8'h00;
   localparam logic [3:0] FRAME_BITS = 4'ha;
   localparam logic [15:0] NODE_BIT_CYCLES = 16'h28b1;
   localparam logic [4:0] NODE_BREAK_BITS = 5'h0d;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAKE_WATCH,
      ST_WAKE_LOW,
      ST_ABD_START,
      ST_ABD_FIRST,
      ST_ABD_COUNT
   } abd_state_e;

   typedef enum logic [1:0] {
      NODE_IDLE,
      NODE_BREAK,
      NODE_DELIM,
      NODE_FRAME
   } node_state_e;
endpackage
`default_nettype wire

// *** tb/uart_autobaud_wakeup_checker.sv ***
`default_nettype none
module uart_autobaud_wakeup_checker (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic receive_line,
   input wire logic sync_mode_i,
   input wire logic autobaud_enable_set_i,
   input wire logic autobaud_enable_clr_i,
   input wire logic overflow_clr_i,
   input wire logic rcv_data_read_i,
   input wire logic divisor_wr_i,
   input wire logic autobaud_enable_o,
   input wire logic wake_on_break_enable_o,
   input wire logic autobaud_overflow_flag_o,
   input wire logic receive_int_flag_o,
   input wire logic [15:0] divisor_pair_o,
   input wire logic receive_hold_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   property p_set;
      autobaud_enable_set_i |=> autobaud_enable_o;
   endproperty
   a_set: assert property (p_set) else $error("enable not set");
   property p_hold;
      $rose(autobaud_enable_o) && !wake_on_break_enable_o
         |-> ##2 receive_hold_o;
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_done;
      $fell(autobaud_enable_o) && !$past(autobaud_enable_clr_i)
         |-> ##[0:1] receive_int_flag_o;
   endproperty
   a_done: assert property (p_done) else $error("no flag");
   property p_count;
      autobaud_enable_o && $changed(divisor_pair_o) && !$past(divisor_wr_i)
         |-> divisor_pair_o == $past(divisor_pair_o) + 16'h0001
         || divisor_pair_o == 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("bad step");
   property p_ovf;
      $rose(autobaud_overflow_flag_o) |-> $past(divisor_pair_o) == 16'hffff;
   endproperty
   a_ovf: assert property (p_ovf) else $error("bad overflow");
   property p_ovf_keep;
      autobaud_overflow_flag_o && autobaud_enable_o && overflow_clr_i
         |=> autobaud_overflow_flag_o;
   endproperty
   a_ovf_keep: assert property (p_ovf_keep) else $error("ovf lost");
   property p_read;
      rcv_data_read_i && !autobaud_enable_o && !wake_on_break_enable_o
         && !$fell(autobaud_enable_o) |=> !receive_int_flag_o;
   endproperty
   a_read: assert property (p_read) else $error("flag kept");
   property p_wake_flag;
      wake_on_break_enable_o && !receive_int_flag_o && $fell(receive_line)
         |-> ##[2:9] receive_int_flag_o;
   endproperty
   a_wake_flag: assert property (p_wake_flag)
      else $error("no wake");
   property p_wake_end;
      wake_on_break_enable_o && receive_int_flag_o && $rose(receive_line)
         |-> ##[1:6] !wake_on_break_enable_o;
   endproperty
   a_wake_end: assert property (p_wake_end)
      else $error("wake kept");
   property p_sync;
      sync_mode_i |=> !wake_on_break_enable_o;
   endproperty
   a_sync: assert property (p_sync) else $error("wake in sync");
endmodule
`default_nettype wire

// *** tb/uart_autobaud_wakeup_tb_top.sv ***
`default_nettype none
module uart_autobaud_wakeup_tb_top
   import uart_abd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i, reset_i = 1'b1, busy;
   logic sync_mode_i = 1'b0, sleep_i = 1'b0, wbrk = 1'b0;
   logic wide_divisor_mode_i = 1'b0, high_speed_select_i = 1'b0;
   logic [15:0] divisor_wdata_i = 16'h1234;
   logic [7:0] cmd = 8'h00;
   logic autobaud_enable_o, wake_on_break_enable_o, autobaud_overflow_flag_o;
   logic receive_int_flag_o, receiver_idle_flag_o, receive_hold_o;
   logic [15:0] divisor_pair_o;
   logic [7:0] receive_data_o;
   int miscompares = 0, n_compared = 0, cycles = 0, t, e;
   wire autobaud_enable_set_i = cmd[0];
   wire autobaud_enable_clr_i = cmd[1];
   wire overflow_clr_i = cmd[2];
   wire wake_enable_set_i = cmd[3];
   wire wake_enable_clr_i = cmd[4];
   wire rcv_data_read_i = cmd[5];
   wire divisor_wr_i = cmd[7];
   serial_link_if link_if ();
   autobaud_wake i_autobaud_wake (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .link(link_if),
      .sync_mode_i(sync_mode_i),
      .wide_divisor_mode_i(wide_divisor_mode_i),
      .high_speed_select_i(high_speed_select_i),
      .sleep_i(sleep_i),
      .autobaud_enable_set_i(autobaud_enable_set_i),
      .autobaud_enable_clr_i(autobaud_enable_clr_i),
      .overflow_clr_i(overflow_clr_i),
      .wake_enable_set_i(wake_enable_set_i),
      .wake_enable_clr_i(wake_enable_clr_i),
      .divisor_wr_i(divisor_wr_i),
      .divisor_wdata_i(divisor_wdata_i),
      .rcv_data_read_i(rcv_data_read_i),
      .autobaud_enable_o(autobaud_enable_o),
      .wake_on_break_enable_o(wake_on_break_enable_o),
      .autobaud_overflow_flag_o(autobaud_overflow_flag_o),
      .receive_int_flag_o(receive_int_flag_o),
      .divisor_pair_o(divisor_pair_o),
      .receiver_idle_flag_o(receiver_idle_flag_o),
      .receive_hold_o(receive_hold_o),
      .receive_data_o(receive_data_o)
   );
   // bit time chosen so that no counter tick lands on the fifth rise
   lin_break_node #(.BIT_CYCLES(16'h0105)) i_lin_break_node (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .link(link_if),
      .send_i(cmd[6]),
      .with_break_i(wbrk),
      .busy_o(busy)
   );
   uart_autobaud_wakeup_checker i_checker (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .receive_line(link_if.receive_line),
      .sync_mode_i(sync_mode_i),
      .autobaud_enable_set_i(autobaud_enable_set_i),
      .autobaud_enable_clr_i(autobaud_enable_clr_i),
      .overflow_clr_i(overflow_clr_i),
      .rcv_data_read_i(rcv_data_read_i),
      .divisor_wr_i(divisor_wr_i),
      .autobaud_enable_o(autobaud_enable_o),
      .wake_on_break_enable_o(wake_on_break_enable_o),
      .autobaud_overflow_flag_o(autobaud_overflow_flag_o),
      .receive_int_flag_o(receive_int_flag_o),
      .divisor_pair_o(divisor_pair_o),
      .receive_hold_o(receive_hold_o)
   );

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic pulse(int b);
      @(posedge mclk_i) cmd[b] <= 1'b1;
      @(posedge mclk_i) cmd <= 8'h00;
      @(negedge mclk_i);
   endtask

   // waits for the node to finish, then for the receive pipeline
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20000)
      begin
         @(negedge mclk_i);
         n++;
      end
      repeat (8) @(negedge mclk_i);
   endtask

   task automatic send(logic brk);
      @(posedge mclk_i) wbrk <= brk;
      pulse(6);
   endtask

   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(negedge mclk_i);
      check("divisor", divisor_pair_o, 16'h0000);
      check("idle", 16'(receiver_idle_flag_o), 16'h0001);
      pulse(7);
      check("divisor", divisor_pair_o, 16'h1234);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
      begin
         @(posedge mclk_i) {wide_divisor_mode_i, high_speed_select_i} <= 2'(m);
         t = (m == 3) ? 32 : (m == 0) ? 512 : 128;
         e = 2088 / t + 1;
         pulse(0);
         repeat (2) @(negedge mclk_i);
         check("hold", 16'(receive_hold_o), 16'h0001);
         send(1'b0);
         wait_idle();
         check("enable", 16'(autobaud_enable_o), 16'h0000);
         check("flag", 16'(receive_int_flag_o), 16'h0001);
         check("divisor", divisor_pair_o, 16'(e));
         check("high", 16'(divisor_pair_o[15:8]), 16'h0000);
         check("hold", 16'(receive_hold_o), 16'h0000);
         check("data", 16'(receive_data_o), 16'h0000);
         pulse(5);
         check("flag", 16'(receive_int_flag_o), 16'h0000);
         $display("test calibration mode %0d done", m);
      end
      @(posedge mclk_i) sleep_i <= 1'b1;
      pulse(3);
      pulse(0);
      send(1'b1);
      repeat (1300) @(negedge mclk_i);
      check("wake", 16'(wake_on_break_enable_o), 16'h0001);
      check("hold", 16'(receive_hold_o), 16'h0001);
      check("flag", 16'(receive_int_flag_o), 16'h0001);
      pulse(5);
      check("flag", 16'(receive_int_flag_o), 16'h0000);
      wait_idle();
      check("wake", 16'(wake_on_break_enable_o), 16'h0000);
      check("enable", 16'(autobaud_enable_o), 16'h0000);
      check("divisor", divisor_pair_o, 16'h0042);
      check("flag", 16'(receive_int_flag_o), 16'h0001);
      $display("test wake done");
      @(posedge mclk_i) sleep_i <= 1'b0;
      pulse(5);
      check("idle", 16'(receiver_idle_flag_o), 16'h0001);
      pulse(3);
      send(1'b0);
      repeat (200) @(negedge mclk_i);
      check("wake", 16'(wake_on_break_enable_o), 16'h0001);
      check("flag", 16'(receive_int_flag_o), 16'h0001);
      wait_idle();
      check("wake", 16'(wake_on_break_enable_o), 16'h0000);
      check("hold", 16'(receive_hold_o), 16'h0000);
      check("flag", 16'(receive_int_flag_o), 16'h0001);
      $display("test awake wake done");
      @(posedge mclk_i) sync_mode_i <= 1'b1;
      pulse(3);
      check("wake", 16'(wake_on_break_enable_o), 16'h0000);
      @(posedge mclk_i) sync_mode_i <= 1'b0;
      pulse(3);
      check("wake", 16'(wake_on_break_enable_o), 16'h0001);
      pulse(4);
      check("wake", 16'(wake_on_break_enable_o), 16'h0000);
      pulse(0);
      pulse(1);
      pulse(2);
      check("enable", 16'(autobaud_enable_o), 16'h0000);
      check("ovf", 16'(autobaud_overflow_flag_o), 16'h0000);
      $display("test abort done");
      print_verdict();
   end
endmodule
`default_nettype wire
